// ### rtl/motor_param_config_bank.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Dither field: 00 none, 01 five, 10 ten, 11 fifteen percent spread.
// R2: Tach select 00 toggles always; 10 closed loop and first open loop; 11 reserved.
// R3: Tach select 01 silent in open loop, starts about 280 ms into closed loop.
// R4: Tach frequency is electrical speed divided by pole divider plus one.
// R5: Clock adjust bit clear means full-cycle, set means half-cycle adjustment.
// R6: Resistance code is mantissa shifted left by exponent.
// R7: Host splits resistance over 0.009615 into mantissa and exponent.
// R8: BEMF constant is bits 11:8 shifted left by bits 14:12.
// R9: Policy bit clear keeps advance fixed relative to estimated back-EMF.
// R10: Policy bit set scales advance by supply minus back-EMF over supply.
// R11: Advance time is bits 3:0 shifted left by bits 6:4.
// R12: Host leaves bit 15 of the constant register alone; it reads zero.
// R13: Constant and advance register at 0x91, reset zero, bit 15 reserved.
// R14: Startup register at 0x92, reset zero, fully read-write with listed fields.
// R15: Tach and resistance register at 0x90, reset zero, all fields read-write.
// R16: Reserved bits ignore writes and read zero.
module motor_param_config_bank #(
  parameter longint unsigned TACH_DELAY_CYCLES = motor_cfg_pkg::TACH_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register port from the serial slave
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  output logic [15:0] reg_rdata_out,
  // Motor engine status and events
  input wire logic closed_loop_in,
  input wire logic elec_edge_in,
  // Tach
  output logic tach_output_out,
  // Decoded configuration
  output logic [1:0] spread_dither_select_out,
  output logic clock_adjust_granularity_out,
  output logic [10:0] resistance_code_out,
  output logic [10:0] constant_code_out,
  output logic advance_timing_policy_out,
  output logic [10:0] advance_time_out,
  output logic [15:0] startup_cfg_out
);

  // Eleven bits hold the widest mantissa after the largest shift
  function automatic logic [10:0] mant_shift(input logic [3:0] m, input logic [2:0] e);
    mant_shift = {7'h00, m} << e;
  endfunction

  // Address decode shared by the write and read paths; 2'h3 means no register here
  function automatic logic [1:0] reg_slot(input logic [7:0] addr);
    unique case (addr)
      motor_cfg_pkg::TACH_RES_ADDR: reg_slot = 2'h0;
      motor_cfg_pkg::BEMF_ADV_ADDR: reg_slot = 2'h1;
      motor_cfg_pkg::STARTUP_ADDR: reg_slot = 2'h2;
      default: reg_slot = 2'h3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  logic [15:0] tach_res_r, tach_res_nxt;
  logic [15:0] bemf_adv_r, bemf_adv_nxt;
  logic [15:0] startup_r, startup_nxt;

  // Masks drop writes to reserved bits, so those bits can never read back as one
  always_comb begin
    tach_res_nxt = tach_res_r;
    bemf_adv_nxt = bemf_adv_r;
    startup_nxt = startup_r;
    if (reg_wr_in) begin
      unique case (reg_slot(reg_addr_in))
        2'h0: begin
          tach_res_nxt = reg_wdata_in & motor_cfg_pkg::TACH_RES_WMASK; // R15
        end
        2'h1: begin
          bemf_adv_nxt = reg_wdata_in & motor_cfg_pkg::BEMF_ADV_WMASK; // R13 R16
        end
        2'h2: begin
          startup_nxt = reg_wdata_in & motor_cfg_pkg::STARTUP_WMASK; // R14
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tach_res_r <= motor_cfg_pkg::TACH_RES_RESET;
      bemf_adv_r <= motor_cfg_pkg::BEMF_ADV_RESET;
      startup_r <= motor_cfg_pkg::STARTUP_RESET;
    end else begin
      tach_res_r <= tach_res_nxt;
      bemf_adv_r <= bemf_adv_nxt;
      startup_r <= startup_nxt;
    end
  end

  // Unmapped addresses read zero
  // Plain mux: read data follows the address within the same cycle
  always_comb begin
    unique case (reg_slot(reg_addr_in))
      2'h0: reg_rdata_out = tach_res_r;
      2'h1: reg_rdata_out = bemf_adv_r; // R16
      2'h2: reg_rdata_out = startup_r;
      default: reg_rdata_out = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  // Dither select leaves undecoded, tach select gates the tach below, and mantissa-exponent pairs are expanded; the engine owns what each code means
  logic [1:0] tach_sel;
  logic [3:0] pole_div;
  assign tach_sel = tach_res_r[motor_cfg_pkg::TACH_OL_LSB +: 2];
  assign pole_div = tach_res_r[motor_cfg_pkg::POLE_DIV_LSB +: 4];
  assign spread_dither_select_out = tach_res_r[motor_cfg_pkg::DITHER_LSB +: 2]; // R1
  assign clock_adjust_granularity_out = tach_res_r[motor_cfg_pkg::CLK_ADJ_BIT]; // R5
  assign resistance_code_out = mant_shift(tach_res_r[motor_cfg_pkg::RES_MANT_LSB +: 4],
    tach_res_r[motor_cfg_pkg::RES_EXP_LSB +: 3]); // R6
  assign constant_code_out = mant_shift(bemf_adv_r[motor_cfg_pkg::CONST_MANT_LSB +: 4],
    bemf_adv_r[motor_cfg_pkg::CONST_EXP_LSB +: 3]); // R8
  // The engine applies fixed or scaled advance from this bit
  assign advance_timing_policy_out = bemf_adv_r[motor_cfg_pkg::ADV_POLICY_BIT]; // R9 R10
  assign advance_time_out = mant_shift(bemf_adv_r[motor_cfg_pkg::ADV_MANT_LSB +: 4],
    bemf_adv_r[motor_cfg_pkg::ADV_EXP_LSB +: 3]); // R11
  assign startup_cfg_out = startup_r; // R14

  ////////////////////////////////////////////////////////////////////////////
  // Loop history

  logic seen_closed_r, seen_closed_nxt;
  logic first_ol_r, first_ol_nxt;

  // The first open-loop run is the one before closed loop is ever reached
  always_comb begin
    seen_closed_nxt = seen_closed_r | closed_loop_in;
    first_ol_nxt = first_ol_r;
    if (!closed_loop_in && seen_closed_r) begin
      first_ol_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seen_closed_r <= 1'b0;
      first_ol_r <= 1'b1;
    end else begin
      seen_closed_r <= seen_closed_nxt;
      first_ol_r <= first_ol_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Closed-loop hold-off

  // A 32-bit count limits the hold-off to about four billion cycles
  logic [31:0] delay_cnt_r, delay_cnt_nxt;
  logic delay_done_r, delay_done_nxt;

  // Any drop out of closed loop restarts the hold-off from zero
  always_comb begin
    delay_cnt_nxt = delay_cnt_r;
    delay_done_nxt = delay_done_r;
    if (!closed_loop_in) begin
      delay_cnt_nxt = 32'h0000_0000;
      delay_done_nxt = 1'b0;
    end else if (!delay_done_r) begin
      if (delay_cnt_r >= 32'(TACH_DELAY_CYCLES - 1)) begin
        delay_done_nxt = 1'b1; // R3
      end else begin
        delay_cnt_nxt = delay_cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      delay_cnt_r <= 32'h0000_0000;
      delay_done_r <= 1'b0;
    end else begin
      delay_cnt_r <= delay_cnt_nxt;
      delay_done_r <= delay_done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tach divider

  logic [3:0] div_cnt_r, div_cnt_nxt;
  logic tach_r, tach_nxt;
  logic tach_gate;

  // Gating off clears the divider but holds the level, so no runt pulse leaves the pin
  always_comb begin
    unique case (tach_sel)
      motor_cfg_pkg::TACH_ALWAYS: tach_gate = 1'b1; // R2
      motor_cfg_pkg::TACH_CLOSED_DELAYED: tach_gate = closed_loop_in & delay_done_r; // R3
      motor_cfg_pkg::TACH_CLOSED_FIRST_OL: tach_gate = closed_loop_in | first_ol_r; // R2
      default: tach_gate = 1'b0; // R2
    endcase
    div_cnt_nxt = div_cnt_r;
    tach_nxt = tach_r;
    if (!tach_gate) begin
      div_cnt_nxt = 4'h0;
    end else if (elec_edge_in) begin
      if (div_cnt_r >= pole_div) begin
        div_cnt_nxt = 4'h0;
        tach_nxt = ~tach_r; // R4
      end else begin
        div_cnt_nxt = div_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_cnt_r <= 4'h0;
      tach_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      tach_r <= tach_nxt;
    end
  end

  assign tach_output_out = tach_r;

endmodule

// ### rtl/motor_cfg_pkg.sv
package motor_cfg_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;

  // Register addresses
  localparam logic [7:0] TACH_RES_ADDR = 8'h90;
  localparam logic [7:0] BEMF_ADV_ADDR = 8'h91;
  localparam logic [7:0] STARTUP_ADDR = 8'h92;

  // Values after reset
  localparam logic [15:0] TACH_RES_RESET = 16'h0000;
  localparam logic [15:0] BEMF_ADV_RESET = 16'h0000;
  localparam logic [15:0] STARTUP_RESET = 16'h0000;

  // Writable bits per register; reserved bits are zero here
  localparam logic [15:0] TACH_RES_WMASK = 16'hFFFF;
  localparam logic [15:0] BEMF_ADV_WMASK = 16'h7FFF;
  localparam logic [15:0] STARTUP_WMASK = 16'hFFFF;

  // Field positions, tach and resistance register
  localparam int unsigned DITHER_LSB = 14;
  localparam int unsigned TACH_OL_LSB = 12;
  localparam int unsigned POLE_DIV_LSB = 8;
  localparam int unsigned CLK_ADJ_BIT = 7;
  localparam int unsigned RES_EXP_LSB = 4;
  localparam int unsigned RES_MANT_LSB = 0;

  // Field positions, constant and advance register
  localparam int unsigned CONST_EXP_LSB = 12;
  localparam int unsigned CONST_MANT_LSB = 8;
  localparam int unsigned ADV_POLICY_BIT = 7;
  localparam int unsigned ADV_EXP_LSB = 4;
  localparam int unsigned ADV_MANT_LSB = 0;

  // Field positions, startup register
  localparam int unsigned STAT_THR_LSB = 14;
  localparam int unsigned BRAKE_CUR_BIT = 13;
  localparam int unsigned HYST_BIT = 12;
  localparam int unsigned INIT_SPEED_BIT = 11;
  localparam int unsigned REVERSE_BIT = 10;
  localparam int unsigned REV_THR_LSB = 8;
  localparam int unsigned OL_CUR_LSB = 6;
  localparam int unsigned RAMP_LSB = 3;
  localparam int unsigned BRAKE_DUR_LSB = 0;

  // Dither codes
  typedef enum logic [1:0] {
    DITHER_OFF = 2'b00,
    DITHER_5PCT = 2'b01,
    DITHER_10PCT = 2'b10,
    DITHER_15PCT = 2'b11
  } dither_t;

  // Tach open-loop select codes
  typedef enum logic [1:0] {
    TACH_ALWAYS = 2'b00,
    TACH_CLOSED_DELAYED = 2'b01,
    TACH_CLOSED_FIRST_OL = 2'b10,
    TACH_RESERVED = 2'b11
  } tach_sel_t;

  // Closed-loop tach hold-off
  localparam int unsigned TACH_DELAY_MS = 280;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned TACH_DELAY_CYC = longint'(TACH_DELAY_MS) * CLK_HZ / 1000;

endpackage

// ### tb/motor_param_config_bank_chk.sv
`timescale 1ns/1ps
module bank_chk (
  // Clock, reset and register port
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_rdata_out,
  // Engine events and decoded outputs
  input wire logic elec_edge_in,
  input wire logic tach_output_out,
  input wire logic [1:0] spread_dither_select_out,
  input wire logic clock_adjust_granularity_out,
  input wire logic [10:0] resistance_code_out,
  input wire logic [10:0] constant_code_out,
  input wire logic advance_timing_policy_out,
  input wire logic [10:0] advance_time_out,
  input wire logic [15:0] startup_cfg_out
);
  logic [15:0] w;
  logic w0, w1, w2;
  always_ff @(posedge clk_in) w <= reg_wdata_in;
  assign w0 = reg_wr_in && reg_addr_in == 8'h90;
  assign w1 = reg_wr_in && reg_addr_in == 8'h91;
  assign w2 = reg_wr_in && reg_addr_in == 8'h92;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  dither_sel_a: assert property (w0 |=> spread_dither_select_out == w[15:14])
    else $error("dither");
  clk_adj_a: assert property (w0 |=> clock_adjust_granularity_out == w[7])
    else $error("adjust");
  res_code_a: assert property (w0 |=> resistance_code_out == 11'(w[3:0]) << w[6:4])
    else $error("resistance");
  kconst_code_a: assert property (w1 |=> constant_code_out == 11'(w[11:8]) << w[14:12])
    else $error("constant");
  adv_time_a: assert property (w1 |=> advance_time_out == 11'(w[3:0]) << w[6:4])
    else $error("advance");
  adv_policy_a: assert property (w1 |=> advance_timing_policy_out == w[7])
    else $error("policy");
  startup_cfg_a: assert property (w2 |=> startup_cfg_out == w)
    else $error("startup");
  rsv_bit_a: assert property (reg_addr_in == 8'h91 |-> !reg_rdata_out[15])
    else $error("reserved");
  unmapped_rd_a: assert property (reg_addr_in > 8'h92 |-> reg_rdata_out == 16'h0000)
    else $error("unmapped");
  tach_hold_a: assert property (!elec_edge_in |=> $stable(tach_output_out))
    else $error("tach");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind motor_param_config_bank bank_chk chk (.clk_in, .resetn_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rdata_out, .elec_edge_in, .tach_output_out,
  .spread_dither_select_out, .clock_adjust_granularity_out, .resistance_code_out,
  .constant_code_out, .advance_timing_policy_out, .advance_time_out, .startup_cfg_out);

// ### tb/cfg_host.sv
`timescale 1ns/1ps
module cfg_host (
  input wire logic clk_in,
  output logic [7:0] addr_out = 8'h00,
  output logic [15:0] wdata_out = 16'h0000,
  output logic wr_out = 0
);
  // Polite writes keep the reserved top bit clear; rude ones probe the refusal
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit rude);
    addr_out <= a;
    wdata_out <= (rude || a != 8'h91) ? d : d & 16'h7FFF;
    wr_out <= 1;
    @(posedge clk_in);
    wr_out <= 0;
    wdata_out <= ~d;
    @(posedge clk_in);
  endtask
  // Keep the four top significant bits of a raw code; the shift counts what was dropped
  function automatic logic [6:0] split_res(input logic [10:0] raw);
    logic [2:0] e;
    e = 3'h0;
    for (int k = 4; k < 11; k++) begin
      if (raw[k]) begin
        e = 3'(k - 3);
      end
    end
    split_res = {e, 4'(raw >> e)};
  endfunction
  task automatic rd(input logic [7:0] a);
    addr_out <= a;
    @(posedge clk_in);
  endtask
endmodule

// ### tb/tb_motor_param_config_bank.sv
`timescale 1ns/1ps
module tb_motor_param_config_bank;
  logic clk_in = 0, resetn_in = 0, closed_loop_in = 0, elec_edge_in = 0, look = 0;
  logic [1:0] kind = 2'h0;
  logic [10:0] resistance_code_out;
  logic [7:0] reg_addr_in, ad [3] = '{8'h90, 8'h91, 8'h92};
  logic [15:0] reg_wdata_in, reg_rdata_out, d, q [$], mk [3] = '{16'hFFFF, 16'h7FFF, 16'hFFFF};
  logic reg_wr_in, tach_output_out;
  int fail_count = 0, samples_checked = 0, tcnt = 0, seed = 1;
  always #5 clk_in = ~clk_in;
  cfg_host host (.clk_in, .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in));
  motor_param_config_bank #(.TACH_DELAY_CYCLES(20)) dut (.clk_in, .resetn_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rdata_out, .closed_loop_in, .elec_edge_in,
    .tach_output_out, .spread_dither_select_out(), .clock_adjust_granularity_out(),
    .resistance_code_out, .constant_code_out(), .advance_timing_policy_out(),
    .advance_time_out(), .startup_cfg_out());
  ////////////////////////////////////////////////////////////////////////////////
  always @(tach_output_out) tcnt++;
  always @(negedge clk_in) begin
    if (look && kind == 2'h0) check("reg_rdata_out", reg_rdata_out, q.pop_front());
    if (look && kind == 2'h1) check("tach_toggles", 16'(tcnt), q.pop_front());
    if (look && kind == 2'h2) check("resistance_code_out", 16'(resistance_code_out), q.pop_front());
  end
  task automatic check(input string what, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s exp %h seen %h", what, e, s);
    end
  endtask
  task automatic note(input logic [1:0] k, input logic [15:0] e);
    q.push_back(e);
    kind <= k;
    look <= 1;
    @(posedge clk_in);
    look <= 0;
  endtask
  // Edge counts are multiples of the divide ratio so the divider ends each run at zero
  task automatic tach(input logic [1:0] s, input logic [3:0] n, input logic cl, input int e, x);
    host.wr(8'h90, {2'b00, s, n, 8'h00}, 0);
    closed_loop_in <= cl;
    @(posedge clk_in);
    tcnt = 0;
    repeat (e) begin
      elec_edge_in <= 1;
      @(posedge clk_in);
      elec_edge_in <= 0;
      @(posedge clk_in);
    end
    @(posedge clk_in);
    note(1, 16'(x));
  endtask
  // Low bits that the host's split drops come back as zero
  task automatic res(input logic [10:0] raw);
    logic [6:0] f;
    f = host.split_res(raw);
    host.wr(8'h90, {9'h000, f}, 0);
    note(2'h2, 16'((raw >> f[6:4]) << f[6:4]));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1;
    for (int i = 0; i < 3; i++) begin
      host.rd(ad[i]);
      note(0, 16'h0000);
      d = 16'($random(seed));
      host.wr(ad[i], d, 1);
      host.rd(ad[i]);
      note(0, d & mk[i]);
    end
    host.wr(8'h93, 16'hFFFF, 0);
    host.rd(8'h93);
    note(0, 16'h0000);
    res(11'h00B);
    res(11'h5A3);
    res(11'($random(seed)));
    tach(2'b10, 4'h1, 0, 4, 2);
    tach(2'b00, 4'h3, 0, 8, 2);
    tach(2'b01, 4'h0, 1, 4, 0);
    repeat (20) @(posedge clk_in);
    tach(2'b01, 4'h0, 1, 4, 4);
    tach(2'b10, 4'h0, 0, 4, 0);
    tach(2'b11, 4'h0, 1, 4, 0);
    tach(2'b00, 4'hF, 1, 16, 1);
    conclude();
  end
endmodule
